// File: iogcd_regs.svh
// register offsets, command codes and field constants of the generic command decoder
`ifndef IOGCD_REGS_SVH
`define IOGCD_REGS_SVH

`define IOGCD_OFS_CMD_CODE    16'h1F3F
`define IOGCD_OFS_PARAM_CNT   16'h1F40
`define IOGCD_OFS_DEST        16'h1F41
`define IOGCD_OFS_SEC_TYPE    16'h1F42
`define IOGCD_OFS_PWD_HI      16'h1F43
`define IOGCD_OFS_PWD_LO      16'h1F44
`define IOGCD_OFS_PARAM0      16'h1F45
`define IOGCD_OFS_PARAM1      16'h1F46

`define IOGCD_CODE_OUT_CHG    16'h0688
`define IOGCD_CODE_ALM_RST    16'hA08B
`define IOGCD_CODE_SIMPLE_EN  16'hA08C
`define IOGCD_CODE_LATCH_ACK  16'hA08E
`define IOGCD_CODE_MINMAX_RST 16'hA78A

`define IOGCD_CNT_OUT_CHG     16'h000D
`define IOGCD_CNT_NO_PAYLOAD  16'h000A
`define IOGCD_CNT_ONE_WORD    16'h000B

`define IOGCD_DEST_IO1        16'h2001
`define IOGCD_DEST_IO2        16'h2101
`define IOGCD_SEC_TYPE_PWD    16'h0001

`define IOGCD_VAL_OFF         16'h0000
`define IOGCD_VAL_ON          16'h0100
`define IOGCD_ACK_ALL         8'hFF

`define IOGCD_ERR_NONE        8'h00
`define IOGCD_ERR_CODE        8'h01
`define IOGCD_ERR_COUNT       8'h02
`define IOGCD_ERR_DEST        8'h03
`define IOGCD_ERR_SEC         8'h04
`define IOGCD_ERR_PWD         8'h05
`define IOGCD_ERR_PARAM       8'h06

`endif

// File: iogcd_pkg.sv
// types shared by the generic command decoder
package iogcd_pkg;
  typedef enum logic [1:0] {
    IOGCD_IDLE,
    IOGCD_CHECK,
    IOGCD_EXEC
  } iogcd_state_type;
endpackage

// File: iogcd_core.sv
// generic command decoder for the io module command register block
//
// Behaviour
// - a command runs only when its password matches the administrator or operator password.
// - output change is code 1672 with a parameter byte count of 13.
// - destination 8193 selects the first io module and 8449 the second one.
// - the first payload word of output change names output 1 to 3.
// - value 0x0000 turns the selected output off and 0x0100 turns it on.
// - only outputs configured as user-defined may be changed by output change.
// - alarm reset is code 41099 with byte count 10 and clears the module alarm status.
// - simple-command enable/disable is code 41100 with byte count 11.
// - payload high byte 0 disables and 1 enables simple commands, the low byte must be 0.
// - latched-output acknowledge is code 41102 with byte count 11.
// - ack high byte 1, 2 or 3 unlatches that relay and 0xFF unlatches all of them.
// - min/max reset is code 42890 with byte count 10 and clears stored analog extremes.
// - generic commands run whatever application is configured on the module.
`timescale 1ns/1ps
`default_nettype none
`include "iogcd_regs.svh"

module iogcd_core #(
  parameter logic [15:0] MODULE_DEST = `IOGCD_DEST_IO1,
  parameter int          NUM_OUT     = 3
) (
  input  wire logic               clk_sys_i,
  input  wire logic               rst_i,
  input  wire logic               reg_wr_i,
  input  wire logic [15:0]        reg_addr_i,
  input  wire logic [15:0]        reg_wdata_i,
  input  wire logic               cmd_go_i,
  input  wire logic [31:0]        admin_pwd_i,
  input  wire logic [31:0]        oper_pwd_i,
  input  wire logic [NUM_OUT-1:0] user_out_cfg_i,
  input  wire logic [NUM_OUT-1:0] latch_set_i,
  output logic [NUM_OUT-1:0]      dig_out_o,
  output logic [NUM_OUT-1:0]      relay_latched_o,
  output logic                    simple_cmd_en_o,
  output logic                    alarm_clear_o,
  output logic                    minmax_clear_o,
  output logic                    cmd_done_o,
  output logic                    cmd_busy_o,
  output logic [7:0]              cmd_error_o
);

  logic [15:0] code_r;
  logic [15:0] cnt_r;
  logic [15:0] dest_r;
  logic [15:0] sec_r;
  logic [31:0] pwd_r;
  logic [15:0] par0_r;
  logic [15:0] par1_r;
  iogcd_pkg::iogcd_state_type state_r;
  logic [7:0]  err_nxt;
  logic        busy_w;

  // busy_w freezes the block so a running command never sees a half-written word
  assign busy_w = (state_r != iogcd_pkg::IOGCD_IDLE);

  // command block, filled word by word by the master; writes during a check are ignored
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      code_r <= 16'h0000;
      cnt_r  <= 16'h0000;
      dest_r <= 16'h0000;
      sec_r  <= 16'h0000;
      pwd_r  <= 32'h0000_0000;
      par0_r <= 16'h0000;
      par1_r <= 16'h0000;
    end else if (reg_wr_i && !busy_w) begin
      unique case (reg_addr_i)
        `IOGCD_OFS_CMD_CODE:  code_r        <= reg_wdata_i;
        `IOGCD_OFS_PARAM_CNT: cnt_r         <= reg_wdata_i;
        `IOGCD_OFS_DEST:      dest_r        <= reg_wdata_i;
        `IOGCD_OFS_SEC_TYPE:  sec_r         <= reg_wdata_i;
        `IOGCD_OFS_PWD_HI:    pwd_r[31:16]  <= reg_wdata_i;
        `IOGCD_OFS_PWD_LO:    pwd_r[15:0]   <= reg_wdata_i;
        `IOGCD_OFS_PARAM0:    par0_r        <= reg_wdata_i;
        `IOGCD_OFS_PARAM1:    par1_r        <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // validation in priority order: code, count, destination, security, password, payload
  // the first failing check names the error, so the master learns one cause at a time;
  // the block words stay frozen from check to execute, but the password compare and the user-defined test also read live inputs
  always_comb begin
    err_nxt = `IOGCD_ERR_NONE;
    unique case (code_r)
      `IOGCD_CODE_OUT_CHG: begin
        if (cnt_r != `IOGCD_CNT_OUT_CHG) err_nxt = `IOGCD_ERR_COUNT;
      end
      `IOGCD_CODE_ALM_RST,
      `IOGCD_CODE_MINMAX_RST: begin
        if (cnt_r != `IOGCD_CNT_NO_PAYLOAD) err_nxt = `IOGCD_ERR_COUNT;
      end
      `IOGCD_CODE_SIMPLE_EN,
      `IOGCD_CODE_LATCH_ACK: begin
        if (cnt_r != `IOGCD_CNT_ONE_WORD) err_nxt = `IOGCD_ERR_COUNT;
      end
      default: err_nxt = `IOGCD_ERR_CODE;
    endcase
    if (err_nxt == `IOGCD_ERR_NONE) begin
      if (dest_r != MODULE_DEST) begin
        err_nxt = `IOGCD_ERR_DEST;
      end else if (sec_r != `IOGCD_SEC_TYPE_PWD) begin
        err_nxt = `IOGCD_ERR_SEC;
      // whole 32-bit compare: the high half came from the lower address
      end else if (pwd_r != admin_pwd_i && pwd_r != oper_pwd_i) begin
        err_nxt = `IOGCD_ERR_PWD;
      end else if (code_r == `IOGCD_CODE_OUT_CHG) begin
        // output number 1..3, value on/off, and the output must be user-defined
        if (par0_r == 16'h0000 || par0_r > 16'(NUM_OUT)) begin
          err_nxt = `IOGCD_ERR_PARAM;
        end else if (par1_r != `IOGCD_VAL_OFF && par1_r != `IOGCD_VAL_ON) begin
          err_nxt = `IOGCD_ERR_PARAM;
        end else if (!user_out_cfg_i[par0_r[1:0] - 2'h1]) begin
          err_nxt = `IOGCD_ERR_PARAM;
        end
      end else if (code_r == `IOGCD_CODE_SIMPLE_EN) begin
        if (par0_r[7:0] != 8'h00 || par0_r[15:8] > 8'h01) err_nxt = `IOGCD_ERR_PARAM;
      end else if (code_r == `IOGCD_CODE_LATCH_ACK) begin
        if (par0_r[15:8] != `IOGCD_ACK_ALL &&
            (par0_r[15:8] == 8'h00 || par0_r[15:8] > 8'(NUM_OUT))) begin
          err_nxt = `IOGCD_ERR_PARAM;
        end
      end
    end
  end

  // go -> check (one cycle to settle the block) -> execute -> idle; no application gating
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= iogcd_pkg::IOGCD_IDLE;
    end else begin
      unique case (state_r)
        iogcd_pkg::IOGCD_IDLE: begin
          // a go outside idle never reaches this item, so it is simply dropped
          if (cmd_go_i) begin
            state_r <= iogcd_pkg::IOGCD_CHECK;
          end
        end
        iogcd_pkg::IOGCD_CHECK: begin
          // one spare cycle lets the last written word settle into the checks
          state_r <= iogcd_pkg::IOGCD_EXEC;
        end
        iogcd_pkg::IOGCD_EXEC: begin
          // effects and status are taken on this edge, then the block reopens
          state_r <= iogcd_pkg::IOGCD_IDLE;
        end
        default: begin
          // the unused fourth code falls back to idle instead of locking up
          state_r <= iogcd_pkg::IOGCD_IDLE;
        end
      endcase
    end
  end

  // status: error code held until the next command, done is a one-cycle pulse
  // go taken at edge E: check at E+1, execute at E+2, so done and the clear
  // strobes show for one cycle after E+2 and busy covers E up to E+2
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_error_o <= `IOGCD_ERR_NONE;
      cmd_done_o  <= 1'b0;
      cmd_busy_o  <= 1'b0;
    end else begin
      cmd_done_o <= (state_r == iogcd_pkg::IOGCD_EXEC);
      cmd_busy_o <= (state_r == iogcd_pkg::IOGCD_IDLE) ? cmd_go_i
                                                        : (state_r != iogcd_pkg::IOGCD_EXEC);
      if (state_r == iogcd_pkg::IOGCD_EXEC) cmd_error_o <= err_nxt;
    end
  end

  // digital outputs and simple-command enable
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      dig_out_o       <= '0;
      simple_cmd_en_o <= 1'b1;
    end else if (state_r == iogcd_pkg::IOGCD_EXEC && err_nxt == `IOGCD_ERR_NONE) begin
      if (code_r == `IOGCD_CODE_OUT_CHG) begin
        dig_out_o[par0_r[1:0] - 2'h1] <= (par1_r == `IOGCD_VAL_ON);
      end
      if (code_r == `IOGCD_CODE_SIMPLE_EN) begin
        simple_cmd_en_o <= par0_r[8];
      end
    end
  end

  // relay latches: a new latch event wins over an acknowledge in the same cycle
  // so a relay that trips again during the acknowledge stays latched
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      relay_latched_o <= '0;
    end else begin
      for (int i = 0; i < NUM_OUT; i++) begin
        if (latch_set_i[i]) begin
          relay_latched_o[i] <= 1'b1;
        end else if (state_r == iogcd_pkg::IOGCD_EXEC && err_nxt == `IOGCD_ERR_NONE &&
                     code_r == `IOGCD_CODE_LATCH_ACK &&
                     (par0_r[15:8] == `IOGCD_ACK_ALL || par0_r[15:8] == 8'(i + 1))) begin
          relay_latched_o[i] <= 1'b0;
        end
      end
    end
  end

  // one-cycle clear strobes toward the alarm status and analog extreme stores
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      alarm_clear_o  <= 1'b0;
      minmax_clear_o <= 1'b0;
    end else begin
      alarm_clear_o  <= state_r == iogcd_pkg::IOGCD_EXEC && err_nxt == `IOGCD_ERR_NONE &&
                        code_r == `IOGCD_CODE_ALM_RST;
      minmax_clear_o <= state_r == iogcd_pkg::IOGCD_EXEC && err_nxt == `IOGCD_ERR_NONE &&
                        code_r == `IOGCD_CODE_MINMAX_RST;
    end
  end

endmodule

`default_nettype wire

// File: iogcd_core_properties.sv
// port-level assertions for the generic command decoder
`timescale 1ns/1ps
`default_nettype none
module iogcd_core_properties #(parameter int NUM_OUT = 3) (
  input wire logic               clk_sys_i,
  input wire logic               rst_i,
  input wire logic               cmd_go_i,
  input wire logic               cmd_busy_o,
  input wire logic               cmd_done_o,
  input wire logic [NUM_OUT-1:0] user_out_cfg_i,
  input wire logic [NUM_OUT-1:0] latch_set_i,
  input wire logic [NUM_OUT-1:0] dig_out_o,
  input wire logic [NUM_OUT-1:0] relay_latched_o,
  input wire logic               simple_cmd_en_o,
  input wire logic               alarm_clear_o,
  input wire logic               minmax_clear_o,
  input wire logic [7:0]         cmd_error_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // done register lands on the third sampled edge after the go edge
  sequence s_answer;
    ##3 cmd_done_o;
  endsequence
  // the pulse that moved outputs was checked against the previous configuration
  sequence s_user_only;
    ((dig_out_o ^ $past(dig_out_o)) & ~$past(user_out_cfg_i)) == '0;
  endsequence
  sequence s_latch_caused;
    (relay_latched_o & ~$past(relay_latched_o) & ~$past(latch_set_i)) == '0;
  endsequence
  sequence s_ok;
    cmd_done_o && cmd_error_o == 8'h00;
  endsequence
  AST_GO_DONE: assert property (cmd_go_i && !cmd_busy_o && !cmd_done_o |-> s_answer)
    else $error("go without done");
  AST_DONE_ONE: assert property (cmd_done_o |=> !cmd_done_o)
    else $error("done longer than one cycle");
  AST_DONE_CAUSE: assert property (cmd_done_o |-> $past(cmd_go_i, 3))
    else $error("done without go");
  AST_ALM_OK: assert property (alarm_clear_o |-> s_ok)
    else $error("alarm clear without good command");
  AST_MINMAX_OK: assert property (minmax_clear_o |-> s_ok)
    else $error("min max clear without good command");
  AST_OUT_USER: assert property ($changed(dig_out_o) |-> s_user_only)
    else $error("non user output changed");
  AST_OUT_WHEN: assert property ($changed(dig_out_o) |-> s_ok)
    else $error("output moved outside a good command");
  AST_EN_WHEN: assert property ($changed(simple_cmd_en_o) |-> s_ok)
    else $error("enable moved outside a good command");
  AST_LATCH_SET: assert property (s_latch_caused)
    else $error("latch rose without set");
endmodule
bind iogcd_core iogcd_core_properties #(.NUM_OUT(NUM_OUT)) u_props (
  .clk_sys_i       (clk_sys_i),
  .rst_i           (rst_i),
  .cmd_go_i        (cmd_go_i),
  .cmd_busy_o      (cmd_busy_o),
  .cmd_done_o      (cmd_done_o),
  .user_out_cfg_i  (user_out_cfg_i),
  .latch_set_i     (latch_set_i),
  .dig_out_o       (dig_out_o),
  .relay_latched_o (relay_latched_o),
  .simple_cmd_en_o (simple_cmd_en_o),
  .alarm_clear_o   (alarm_clear_o),
  .minmax_clear_o  (minmax_clear_o),
  .cmd_error_o     (cmd_error_o)
);
`default_nettype wire

// File: iogcd_master_model.sv
// register-block master: fills the command words and starts the command
`timescale 1ns/1ps
`default_nettype none
module iogcd_master_model (
  input  wire logic        clk_sys_i,
  input  wire logic        done_i,
  input  wire logic        alarm_i,
  input  wire logic        minmax_i,
  input  wire logic [7:0]  err_i,
  output var  logic        wr_o,
  output var  logic [15:0] addr_o,
  output var  logic [15:0] wdata_o,
  output var  logic        go_o
);
  initial begin
    wr_o = 1'b0;
    addr_o = 16'h0000;
    wdata_o = 16'h0000;
    go_o = 1'b0;
  end
  // slow mode drops the strobe for one cycle before each odd word, as a busy master would
  task automatic run(input logic [15:0] c, n, ds, s, input logic [31:0] p,
                     input logic [15:0] w0, w1, input logic slow,
                     output logic [7:0] e, output logic a, m);
    logic [15:0] w [9];
    w = '{c, n, ds, s, p[31:16], p[15:0], w0, w1, 16'($urandom())};
    for (int i = 0; i < 9; i++) begin
      if (slow && i[0]) begin
        @(posedge clk_sys_i);
        #1 wr_o = 1'b0;
      end
      @(posedge clk_sys_i);
      #1 wr_o = 1'b1;
      addr_o = 16'h1F3F + 16'(i); // last word is unmapped
      wdata_o = w[i];
    end
    @(posedge clk_sys_i);
    #1 wr_o = 1'b0;
    go_o = 1'b1;
    wdata_o = ~wdata_o; // released data must not look valid
    @(posedge clk_sys_i);
    #1 go_o = 1'b0;
    for (int k = 0; k < 8 && !done_i; k++) begin
      @(posedge clk_sys_i);
      #1;
    end
    e = err_i;
    a = alarm_i;
    m = minmax_i;
  endtask
endmodule
`default_nettype wire

// File: tb_io_generic_command_decoder.sv
// self-checking bench for the generic command decoder
`timescale 1ns/1ps
`default_nettype none
`include "iogcd_regs.svh"
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, x); end end
module tb_io_generic_command_decoder;
  logic        clk_sys_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        wr, go, en, ac, mc, done, busy, x_en;
  logic [15:0] addr, wdata;
  logic [31:0] admin = 32'h0, oper = 32'h0;
  logic [2:0]  cfg = 3'h7, lset = 3'h0, dout, lat, x_out, x_lat;
  logic [7:0]  err;
  int          n_fail = 0, cmp_count = 0, cyc = 0;
  iogcd_core DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_wr_i(wr), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .cmd_go_i(go), .admin_pwd_i(admin), .oper_pwd_i(oper),
    .user_out_cfg_i(cfg), .latch_set_i(lset), .dig_out_o(dout), .relay_latched_o(lat),
    .simple_cmd_en_o(en), .alarm_clear_o(ac), .minmax_clear_o(mc), .cmd_done_o(done),
    .cmd_busy_o(busy), .cmd_error_o(err));
  iogcd_master_model M (.clk_sys_i(clk_sys_i), .done_i(done), .alarm_i(ac), .minmax_i(mc),
    .err_i(err), .wr_o(wr), .addr_o(addr), .wdata_o(wdata), .go_o(go));
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // every command result is compared against the expected output state
  task automatic cmd(input logic [15:0] c, n, ds, s, input logic [31:0] p,
                     input logic [15:0] w0, w1, input logic [7:0] xe, input logic xa, xm);
    logic [7:0] e;
    logic       a, m;
    M.run(c, n, ds, s, p, w0, w1, 1'($urandom_range(0, 1)), e, a, m);
    `CHK(e, xe)
    `CHK(a, xa)
    `CHK(m, xm)
    `CHK({dout, lat, en}, {x_out, x_lat, x_en})
    `CHK({busy, done}, 2'h1)
  endtask
  task automatic gcmd(input logic [15:0] c, n, w0, w1, input logic [7:0] xe, input logic xa, xm);
    cmd(c, n, `IOGCD_DEST_IO1, `IOGCD_SEC_TYPE_PWD, $urandom_range(0, 1) ? admin : oper,
        w0, w1, xe, xa, xm);
  endtask
  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 8000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    int         o;
    logic       v;
    logic [7:0] xe;
    logic [7:0] hb [4];
    hb = '{8'h01, 8'h02, 8'h03, 8'hFF};
    void'($urandom(32'h66C9AD0D));
    admin = $urandom();
    oper = $urandom();
    {x_out, x_lat, x_en} = 7'h01;
    repeat (5) @(posedge clk_sys_i);
    #1 rst_i = 1'b0;
    `CHK({dout, lat, en, busy, done, err}, 17'h00400)
    for (int k = 0; k < 12; k++) begin
      o = $urandom_range(1, 3);
      v = 1'($urandom_range(0, 1));
      cfg = 3'($urandom());
      xe = cfg[o-1] ? `IOGCD_ERR_NONE : `IOGCD_ERR_PARAM;
      if (cfg[o-1]) x_out[o-1] = v;
      gcmd(`IOGCD_CODE_OUT_CHG, `IOGCD_CNT_OUT_CHG, 16'(o), v ? `IOGCD_VAL_ON : `IOGCD_VAL_OFF,
           xe, 1'b0, 1'b0);
    end
    cfg = 3'h7;
    foreach (hb[i]) begin
      @(posedge clk_sys_i);
      #1 lset = 3'h7;
      @(posedge clk_sys_i);
      #1 lset = 3'h0;
      x_lat = (hb[i] == 8'hFF) ? 3'h0 : 3'h7 & ~(3'h1 << (hb[i] - 8'h01));
      gcmd(`IOGCD_CODE_LATCH_ACK, `IOGCD_CNT_ONE_WORD, {hb[i], 8'h00}, 16'h0, 8'h00,
           1'b0, 1'b0);
    end
    gcmd(`IOGCD_CODE_ALM_RST, `IOGCD_CNT_NO_PAYLOAD, 16'h0, 16'h0, 8'h00, 1'b1, 1'b0);
    gcmd(`IOGCD_CODE_MINMAX_RST, `IOGCD_CNT_NO_PAYLOAD, 16'h0, 16'h0, 8'h00, 1'b0, 1'b1);
    gcmd(`IOGCD_CODE_SIMPLE_EN, `IOGCD_CNT_ONE_WORD, 16'h0001, 16'h0, 8'h06, 1'b0, 1'b0);
    gcmd(`IOGCD_CODE_SIMPLE_EN, `IOGCD_CNT_ONE_WORD, 16'h0200, 16'h0, 8'h06, 1'b0, 1'b0);
    x_en = 1'b0;
    gcmd(`IOGCD_CODE_SIMPLE_EN, `IOGCD_CNT_ONE_WORD, 16'h0000, 16'h0, 8'h00, 1'b0, 1'b0);
    x_en = 1'b1;
    gcmd(`IOGCD_CODE_SIMPLE_EN, `IOGCD_CNT_ONE_WORD, 16'h0100, 16'h0, 8'h00, 1'b0, 1'b0);
    gcmd(16'h1234, `IOGCD_CNT_NO_PAYLOAD, 16'h0, 16'h0, `IOGCD_ERR_CODE, 1'b0, 1'b0);
    gcmd(`IOGCD_CODE_ALM_RST, `IOGCD_CNT_ONE_WORD, 16'h0, 16'h0, `IOGCD_ERR_COUNT,
         1'b0, 1'b0);
    gcmd(`IOGCD_CODE_OUT_CHG, `IOGCD_CNT_OUT_CHG, 16'h4, `IOGCD_VAL_ON, 8'h06, 1'b0, 1'b0);
    gcmd(`IOGCD_CODE_OUT_CHG, `IOGCD_CNT_OUT_CHG, 16'h1, 16'h0001, 8'h06, 1'b0, 1'b0);
    gcmd(`IOGCD_CODE_LATCH_ACK, `IOGCD_CNT_ONE_WORD, 16'h0400, 16'h0, 8'h06, 1'b0, 1'b0);
    cmd(`IOGCD_CODE_ALM_RST, `IOGCD_CNT_NO_PAYLOAD, `IOGCD_DEST_IO2, `IOGCD_SEC_TYPE_PWD, admin,
        16'h0, 16'h0, `IOGCD_ERR_DEST, 1'b0, 1'b0);
    cmd(`IOGCD_CODE_ALM_RST, `IOGCD_CNT_NO_PAYLOAD, `IOGCD_DEST_IO1, 16'h0002, admin,
        16'h0, 16'h0, `IOGCD_ERR_SEC, 1'b0, 1'b0);
    cmd(`IOGCD_CODE_MINMAX_RST, `IOGCD_CNT_NO_PAYLOAD, `IOGCD_DEST_IO1, `IOGCD_SEC_TYPE_PWD,
        ~admin, 16'h0, 16'h0, `IOGCD_ERR_PWD, 1'b0, 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
